/* File: logic/halt_ctrl_pkg.sv */
// package for the cpu halt, wake and debug-entry controller
// assumes one core clock domain; the core decoder and debug receiver share it
// Contract
// - wait clears the interrupt mask then gates cpu clocks until wake
// - in wait, interrupt or reset restarts clocks and is serviced normally
// - debug-entry command during wait restarts clocks and enters debug halt
// - default stop halts all clocks including oscillator; only external wake resumes; the code also resumes stop on irq_req
// - a configuration keeps minimal clocks in stop for periodic wake
// - debug enable set keeps oscillator running in stop
// - with oscillator alive, debug-entry command in stop enters debug halt
// - debug-break instruction stops user execution and enters debug halt
// - after debug break only reset, go, single step or tagged go resume
// - flag register: overflow 7, half carry 4, mask 3, negative 2
// - zero at bit 1, carry at bit 0 from data bit 7
// - 16-bit memory operand stored high byte first, low at address plus one
// - direct page address uses zero upper byte, lowest 256 locations
// - branch target is signed displacement from the following address
// - bit index is three bits, zero to seven
// - each flag is kept, cleared, set, updated or undefined
// - wide index offset added modulo 16 bits
// - interrupt entry pushes pc low, pc high, x, a, flags, then sets mask
// - after reset a fixed sequence fetches the vector from the top addresses
package halt_ctrl_pkg;
	localparam int FLG_V = 7;
	localparam int FLG_H = 4;
	localparam int FLG_I = 3;
	localparam int FLG_N = 2;
	localparam int FLG_Z = 1;
	localparam int FLG_C = 0;
	localparam logic [7:0]  FLG_RESET    = 8'h08;
	localparam logic [15:0] VEC_RESET_HI = 16'hFFFE;
	localparam logic [15:0] VEC_RESET_LO = 16'hFFFF;
	localparam logic [15:0] ADDR_STEP    = 16'h0001;
	localparam logic [7:0]  DIRECT_PAGE  = 8'h00;
	localparam int RESET_SEQ_CYCLES = 6;
	localparam logic [2:0]  RESET_SEQ_LAST = 3'h5;

	typedef enum logic [2:0] {
		FM_KEEP = 3'h0,
		FM_CLR  = 3'h1,
		FM_SET  = 3'h2,
		FM_UPD  = 3'h3,
		FM_UNDEF= 3'h4
	} flag_mode_t;

	typedef struct packed {
		flag_mode_t v;
		flag_mode_t h;
		flag_mode_t n;
		flag_mode_t z;
		flag_mode_t c;
	} flag_ctl_t;

	typedef struct packed {
		logic go;
		logic single_step_command;
		logic tagged_go_command;
		logic debug_entry;
		logic enable_set;
		logic enable_clr;
	} dbg_cmd_t;

	typedef enum logic [6:0] {
		ST_RESET = 7'h01,
		ST_RUN   = 7'h02,
		ST_WAIT  = 7'h04,
		ST_STOP  = 7'h08,
		ST_DEBUG = 7'h10,
		ST_PUSH  = 7'h20,
		ST_VEC   = 7'h40
	} cpu_state_t;
endpackage

/* File: logic/halt_ctrl.sv */
// cpu halt/wake/debug-entry controller with flag register and address helpers
// assumes instruction decode gives one-cycle completion strobes on mclk;
// serial debug commands arrive already decoded, synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module halt_ctrl
	import halt_ctrl_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        wait_done,
	input  wire logic        stop_done,
	input  wire logic        break_done,
	input  wire logic        irq_req,
	input  wire logic        ext_wake,
	input  wire logic        periodic_wake,
	input  wire logic        stop_keep_clocks,
	input  wire logic        reset_into_debug,
	input  wire dbg_cmd_t    dbg_cmd,
	input  wire logic        alu_valid,
	input  wire flag_ctl_t   alu_ctl,
	input  wire logic [7:0]  alu_result,
	input  wire logic [7:0]  alu_in_a,
	input  wire logic [7:0]  alu_in_m,
	input  wire logic        alu_carry,
	input  wire logic [15:0] pc,
	input  wire logic [7:0]  acc,
	input  wire logic [7:0]  idx_low,
	input  wire logic [15:0] base_reg,
	input  wire logic [15:0] wide_index_offset,
	input  wire logic [7:0]  direct_addr,
	input  wire logic [7:0]  branch_disp,
	input  wire logic [15:0] next_insn_addr,
	input  wire logic [15:0] operand_addr,
	input  wire logic [2:0]  bit_index,
	output logic             cpu_clk_en,
	output logic             osc_en,
	output logic             min_clk_en,
	output logic             debug_halted_state,
	output logic             debug_enable_bit,
	output logic             irq_entry,
	output logic [7:0]       flag_register,
	output logic [7:0]       push_data,
	output logic             push_valid,
	output logic             vec_fetch,
	output logic [15:0]      vec_addr,
	output logic [15:0]      direct_full,
	output logic [15:0]      index_addr,
	output logic [15:0]      branch_target,
	output logic [15:0]      operand_hi_addr,
	output logic [15:0]      operand_lo_addr,
	output logic [7:0]       bit_mask
);
	cpu_state_t state;
	cpu_state_t next_state;
	logic [2:0] seq_cnt;
	logic       resume_cmd;
	logic       stop_wake;

	assign resume_cmd = dbg_cmd.go | dbg_cmd.single_step_command | dbg_cmd.tagged_go_command;
	// periodic wake only counts when the minimal clock set is kept alive
	assign stop_wake = ext_wake | (stop_keep_clocks & periodic_wake) | irq_req;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_RESET:
				if (seq_cnt == RESET_SEQ_LAST)
					next_state = reset_into_debug ? ST_DEBUG : ST_RUN;
			ST_RUN:
				if (break_done)
					next_state = ST_DEBUG;
				else if (wait_done)
					next_state = ST_WAIT;
				else if (stop_done)
					next_state = ST_STOP;
				else if (irq_req && !flag_register[FLG_I])
					next_state = ST_PUSH;
			ST_WAIT:
				if (dbg_cmd.debug_entry)
					next_state = ST_DEBUG;
				else if (irq_req)
					next_state = ST_PUSH;
			ST_STOP:
				if (dbg_cmd.debug_entry && debug_enable_bit)
					next_state = ST_DEBUG;
				else if (irq_req)
					next_state = ST_PUSH;
				else if (stop_wake)
					next_state = ST_RUN;
			ST_DEBUG:
				if (resume_cmd)
					next_state = ST_RUN;
			ST_PUSH:
				if (seq_cnt == 3'h4)
					next_state = ST_VEC;
			ST_VEC:
				if (seq_cnt == 3'h1)
					next_state = ST_RUN;
			default:
				next_state = ST_RESET;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			state <= ST_RESET;
		else
			state <= next_state;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			seq_cnt <= 3'h0;
		else if (next_state != state)
			seq_cnt <= 3'h0;
		else if (state == ST_RESET || state == ST_PUSH || state == ST_VEC)
			seq_cnt <= seq_cnt + 3'h1;
	end

	// debug enable: set by command or by a reset that lands in debug halt
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			debug_enable_bit <= 1'b0;
		else if (dbg_cmd.enable_set || (state == ST_RESET && next_state == ST_DEBUG))
			debug_enable_bit <= 1'b1;
		else if (dbg_cmd.enable_clr)
			debug_enable_bit <= 1'b0;
	end

	// flag register; halted states leave it alone so context survives
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			flag_register <= FLG_RESET;
		else if (state == ST_RUN && wait_done && !break_done)
			flag_register[FLG_I] <= 1'b0;
		else if (state == ST_PUSH && seq_cnt == 3'h4)
			flag_register[FLG_I] <= 1'b1;
		else if (state == ST_RUN && alu_valid)
		begin
			flag_register[FLG_V] <= apply(alu_ctl.v, flag_register[FLG_V],
				(alu_in_a[7] == alu_in_m[7]) && (alu_result[7] != alu_in_a[7]));
			flag_register[FLG_H] <= apply(alu_ctl.h, flag_register[FLG_H],
				alu_in_a[4] ^ alu_in_m[4] ^ alu_result[4]);
			flag_register[FLG_N] <= apply(alu_ctl.n, flag_register[FLG_N], alu_result[7]);
			flag_register[FLG_Z] <= apply(alu_ctl.z, flag_register[FLG_Z], alu_result == 8'h00);
			flag_register[FLG_C] <= apply(alu_ctl.c, flag_register[FLG_C], alu_carry);
		end
	end

	// undefined is resolved as keep: cheapest and deterministic
	function automatic logic apply(input flag_mode_t m, input logic cur, input logic res);
		case (m)
			FM_CLR:  apply = 1'b0;
			FM_SET:  apply = 1'b1;
			FM_UPD:  apply = res;
			default: apply = cur;
		endcase
	endfunction

	// stacking order pc low, pc high, x, a, flags
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			push_data <= 8'h00;
		else
			case (seq_cnt)
				3'h0:    push_data <= pc[7:0];
				3'h1:    push_data <= pc[15:8];
				3'h2:    push_data <= idx_low;
				3'h3:    push_data <= acc;
				default: push_data <= flag_register;
			endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			push_valid <= 1'b0;
		else
			push_valid <= (state == ST_PUSH);
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			vec_fetch <= 1'b0;
			vec_addr  <= 16'h0000;
		end
		else
		begin
			vec_fetch <= (state == ST_RESET) && (seq_cnt < 3'h2);
			vec_addr  <= seq_cnt[0] ? VEC_RESET_LO : VEC_RESET_HI;
		end
	end

	assign cpu_clk_en = (state != ST_WAIT) && (state != ST_STOP);
	assign osc_en = (state != ST_STOP) || debug_enable_bit;
	assign min_clk_en = (state != ST_STOP) || stop_keep_clocks || debug_enable_bit;
	assign debug_halted_state = (state == ST_DEBUG);
	assign irq_entry = (state == ST_PUSH) && (seq_cnt == 3'h0);

	// address helpers, registered so data outputs come from flip-flops
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			direct_full     <= 16'h0000;
			index_addr      <= 16'h0000;
			branch_target   <= 16'h0000;
			operand_hi_addr <= 16'h0000;
			operand_lo_addr <= 16'h0000;
			bit_mask        <= 8'h00;
		end
		else
		begin
			direct_full     <= {DIRECT_PAGE, direct_addr};
			index_addr      <= base_reg + wide_index_offset;
			branch_target   <= next_insn_addr + {{8{branch_disp[7]}}, branch_disp};
			operand_hi_addr <= operand_addr;
			operand_lo_addr <= operand_addr + ADDR_STEP;
			bit_mask        <= 8'h01 << bit_index;
		end
	end

	chk_wait_gates: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_RUN && wait_done && !break_done) |=> (!cpu_clk_en && !flag_register[FLG_I]))
		else $error("wait did not gate clocks or clear mask");
	chk_wait_irq: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_WAIT && irq_req && !dbg_cmd.debug_entry) |=> (cpu_clk_en && irq_entry))
		else $error("irq did not wake from wait");
	chk_wait_debug: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_WAIT && dbg_cmd.debug_entry) |=> (debug_halted_state && cpu_clk_en))
		else $error("debug entry from wait failed");
	chk_stop_osc: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_STOP) |-> (osc_en == debug_enable_bit))
		else $error("oscillator state wrong in stop");
	chk_stop_minclk: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_STOP && stop_keep_clocks) |-> min_clk_en)
		else $error("minimal clocks lost in stop");
	chk_stop_debug: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_STOP && debug_enable_bit && dbg_cmd.debug_entry) |=> debug_halted_state)
		else $error("debug entry from stop failed");
	chk_break_halt: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_RUN && break_done) |=> debug_halted_state)
		else $error("break did not halt");
	chk_debug_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		(debug_halted_state && !resume_cmd) |=> debug_halted_state)
		else $error("left debug halt without resume");
	chk_push_order: assert property (@(posedge mclk) disable iff (!arst_n)
		irq_entry |=> (push_data == $past(pc[7:0])) ##1 (push_data == $past(pc[15:8])))
		else $error("push order wrong");
	chk_direct_page: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (direct_full[15:8] == 8'h00 && direct_full[7:0] == $past(direct_addr)))
		else $error("direct page address wrong");
	chk_reset_seq: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(vec_fetch) |-> vec_addr == VEC_RESET_HI)
		else $error("reset vector fetch wrong");

	// halted states must hold until a legal wake arrives
	chk_wait_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_WAIT && !irq_req && !dbg_cmd.debug_entry) |=> (state == ST_WAIT))
		else $error("wait left without wake");

	chk_stop_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_STOP && !stop_wake && !(dbg_cmd.debug_entry && debug_enable_bit)) |=> (state == ST_STOP))
		else $error("stop left without wake");

	chk_stop_ext: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_STOP && ext_wake && !irq_req && !(dbg_cmd.debug_entry && debug_enable_bit))
		|=> (state == ST_RUN && cpu_clk_en))
		else $error("external wake ignored in stop");

	// periodic wake must be refused while the minimal clock set is off
	chk_stop_periodic: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_STOP && periodic_wake && !stop_keep_clocks && !ext_wake && !irq_req
		&& !(dbg_cmd.debug_entry && debug_enable_bit)) |=> (state == ST_STOP))
		else $error("periodic wake honoured without kept clocks");

	chk_stop_irq: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_STOP && irq_req && !(dbg_cmd.debug_entry && debug_enable_bit)) |=> (irq_entry && cpu_clk_en))
		else $error("irq wake from stop skipped entry");

	chk_stop_refuse: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_STOP && dbg_cmd.debug_entry && !debug_enable_bit && !stop_wake) |=> (state == ST_STOP))
		else $error("debug entry taken in stop without enable");

	chk_enable_osc: assert property (@(posedge mclk) disable iff (!arst_n)
		debug_enable_bit |-> osc_en)
		else $error("oscillator off with debug enabled");

	chk_reset_debug: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_RESET && seq_cnt == RESET_SEQ_LAST && reset_into_debug) |=> (debug_halted_state && debug_enable_bit))
		else $error("reset into debug did not enable debug");

	chk_reset_exit: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_RESET && seq_cnt == RESET_SEQ_LAST && !reset_into_debug) |=> (state == ST_RUN))
		else $error("reset sequence did not end in run");

	chk_vec_pair: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(vec_fetch) |=> (vec_fetch && vec_addr == VEC_RESET_LO))
		else $error("second vector byte wrong");

	chk_wait_over_stop: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_RUN && wait_done && stop_done && !break_done) |=> (state == ST_WAIT))
		else $error("wait lost priority over stop");

	chk_debug_clk: assert property (@(posedge mclk) disable iff (!arst_n)
		debug_halted_state |-> cpu_clk_en)
		else $error("clocks gated in debug halt");

	chk_go_resume: assert property (@(posedge mclk) disable iff (!arst_n)
		(debug_halted_state && dbg_cmd.go) |=> (state == ST_RUN))
		else $error("go did not resume");

	chk_step_resume: assert property (@(posedge mclk) disable iff (!arst_n)
		(debug_halted_state && dbg_cmd.single_step_command) |=> (state == ST_RUN))
		else $error("single step did not resume");

	chk_tagged_resume: assert property (@(posedge mclk) disable iff (!arst_n)
		(debug_halted_state && dbg_cmd.tagged_go_command) |=> (state == ST_RUN))
		else $error("tagged go did not resume");

	// context must survive every halted or sequencing state except the push sequence, which sets the mask
	chk_flag_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		(state != ST_RUN && state != ST_PUSH) |=> $stable(flag_register))
		else $error("flags changed while halted");

	chk_push_mask: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_PUSH && seq_cnt == 3'h4) |=> flag_register[FLG_I])
		else $error("mask not set after stacking");

	chk_push_count: assert property (@(posedge mclk) disable iff (!arst_n)
		irq_entry |=> push_valid [*5] ##1 !push_valid)
		else $error("stacked byte count wrong");

	chk_flag_set: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_RUN && alu_valid && !wait_done && alu_ctl.z == FM_SET) |=> flag_register[FLG_Z])
		else $error("forced zero flag not set");

	chk_carry_upd: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == ST_RUN && alu_valid && !wait_done && alu_ctl.c == FM_UPD)
		|=> (flag_register[FLG_C] == $past(alu_carry)))
		else $error("carry not updated");

	chk_bit_mask: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (bit_mask == (8'h01 << $past(bit_index))))
		else $error("bit mask wrong");

	chk_operand_pair: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (operand_lo_addr == operand_hi_addr + ADDR_STEP))
		else $error("operand byte pair wrong");

	// the sum wraps in 16 bits, so signed and unsigned offsets agree
	chk_index_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (index_addr == 16'($past(base_reg) + $past(wide_index_offset))))
		else $error("indexed address wrong");

	chk_branch_sign: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> (branch_target == 16'($past(next_insn_addr) + {{8{$past(branch_disp[7])}}, $past(branch_disp)})))
		else $error("branch target wrong");
endmodule // halt_ctrl
`default_nettype wire

/* File: dv/debug_host_model.sv */
// host debug model: turns bench requests into one-cycle decoded debug commands
// assumes serial frames are already decoded and synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module debug_host_model
	import halt_ctrl_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic       cmd_fire,
	input  wire logic [2:0] cmd_code,
	output var dbg_cmd_t    dbg_cmd
);
	// code 0 go, 1 single step, 2 tagged go, 3 debug entry, 4 enable set, 5 enable clear
	// the pulse lasts one cycle, as a decoded frame would
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
			dbg_cmd <= '0;
		else
			dbg_cmd <= cmd_fire ? dbg_cmd_t'(6'h20 >> cmd_code) : '0;
endmodule // debug_host_model
`default_nettype wire

/* File: dv/halt_ctrl_bench.sv */
// self-checking bench for halt_ctrl: driver notes expectations, watcher compares
// assumes debug_host_model stands in for the host on the debug pin
`timescale 1ns/1ps
`default_nettype none
module halt_ctrl_bench;
	import halt_ctrl_pkg::*;
	typedef struct {int id; logic [15:0] v;} note_t;
	note_t notes [$];
	int err_total = 0, checks_done = 0, k;
	logic mclk, arst_n, irq_req, ext_wake, periodic_wake, keep, rid, alu_valid, alu_carry, cmd_fire;
	logic [2:0] ins, bit_index, cmd_code;
	logic [7:0] alu_result, alu_in_a, alu_in_m, acc, idx_low, direct_addr, branch_disp;
	logic [15:0] pc, base_reg, wide_index_offset, next_insn_addr, operand_addr;
	flag_ctl_t alu_ctl;
	dbg_cmd_t dbg_cmd;
	logic cpu_clk_en, osc_en, min_clk_en, debug_halted_state, debug_enable_bit, irq_entry, push_valid, vec_fetch;
	logic [7:0] flag_register, push_data, bit_mask;
	logic [15:0] vec_addr, direct_full, index_addr, branch_target, operand_hi_addr, operand_lo_addr;
	logic [7:0] b [5];
	string nm [17] = '{"cpu_clk_en", "osc_en", "min_clk_en", "debug_halted", "debug_enable", "flag_register",
		"push_data", "vec_addr", "direct_full", "index_addr", "branch_target", "operand_hi", "operand_lo",
		"bit_mask", "push_valid", "irq_entry", "vec_fetch"};

	halt_ctrl dut (.mclk, .arst_n, .wait_done(ins[1]), .stop_done(ins[0]), .break_done(ins[2]), .irq_req,
		.ext_wake, .periodic_wake, .stop_keep_clocks(keep), .reset_into_debug(rid), .dbg_cmd, .alu_valid,
		.alu_ctl, .alu_result, .alu_in_a, .alu_in_m, .alu_carry, .pc, .acc, .idx_low, .base_reg,
		.wide_index_offset, .direct_addr, .branch_disp, .next_insn_addr, .operand_addr, .bit_index,
		.cpu_clk_en, .osc_en, .min_clk_en, .debug_halted_state, .debug_enable_bit, .irq_entry, .flag_register,
		.push_data, .push_valid, .vec_fetch, .vec_addr, .direct_full, .index_addr, .branch_target,
		.operand_hi_addr, .operand_lo_addr, .bit_mask);
	debug_host_model host_m (.mclk, .arst_n, .cmd_fire, .cmd_code, .dbg_cmd);

	function automatic logic [15:0] obs(input int id);
		logic [15:0] t [17];
		t = '{16'(cpu_clk_en), 16'(osc_en), 16'(min_clk_en), 16'(debug_halted_state), 16'(debug_enable_bit),
			16'(flag_register), 16'(push_data), vec_addr, direct_full, index_addr, branch_target,
			operand_hi_addr, operand_lo_addr, 16'(bit_mask), 16'(push_valid), 16'(irq_entry), 16'(vec_fetch)};
		return t[id];
	endfunction
	task automatic check(input int id, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm[id], exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		@(posedge mclk);
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic tick(input int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input int id, input logic [15:0] v);
		notes.push_back('{id, v});
	endtask
	// bounded wait, a timeout is a mismatch and ends the run
	task automatic await_out(input int id, input logic [15:0] v);
		for (k = 0; obs(id) !== v && k < 40; k++)
			tick();
		if (k == 40)
		begin
			check(id, obs(id), v);
			tally_and_finish();
		end
		chk(id, v);
	endtask
	task automatic fire(input int s);
		ins[s] = 1'b1;
		tick();
		ins = '0;
	endtask
	task automatic host(input logic [2:0] c);
		cmd_code = c;
		cmd_fire = 1'b1;
		tick();
		cmd_fire = 1'b0;
	endtask
	task automatic alu(input flag_ctl_t c, input logic [7:0] r, input logic cy, input logic [15:0] exp);
		{alu_ctl, alu_result, alu_carry, alu_valid} = {c, r, cy, 1'b1};
		tick();
		alu_valid = 1'b0;
		chk(5, exp);
	endtask
	task automatic do_reset();
		arst_n = 1'b0;
		tick(10);
		chk(5, 16'h0008);
		arst_n = 1'b1;
		await_out(7, 16'hFFFE);
		chk(16, 16'h0001);
		tick();
		chk(7, 16'hFFFF);
		tick(8);
		chk(16, 16'h0000);
	endtask

	always @(negedge mclk)
		while (notes.size() > 0)
		begin
			note_t n;
			n = notes.pop_front();
			check(n.id, obs(n.id), n.v);
		end

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial
	begin
		{ins, irq_req, ext_wake, periodic_wake, keep, rid, alu_valid, alu_carry, cmd_fire, cmd_code} = '0;
		{alu_ctl, alu_result, alu_in_a, alu_in_m, acc, idx_low, pc} = '0;
		{base_reg, wide_index_offset, next_insn_addr, operand_addr, direct_addr, branch_disp, bit_index} = '0;
		k = $urandom(68);
		do_reset();
		chk(3, 16'h0000);
		alu('{FM_SET, FM_SET, FM_SET, FM_SET, FM_SET}, 8'h00, 1'b0, 16'h009F);
		alu('{FM_CLR, FM_CLR, FM_CLR, FM_CLR, FM_CLR}, 8'h00, 1'b0, 16'h0008);
		alu('{FM_KEEP, FM_KEEP, FM_UPD, FM_UPD, FM_UPD}, 8'h80, 1'b1, 16'h000D);
		alu('{FM_KEEP, FM_KEEP, FM_UPD, FM_UPD, FM_UPD}, 8'h00, 1'b0, 16'h000A);
		alu('{FM_UNDEF, FM_UNDEF, FM_UNDEF, FM_UNDEF, FM_UNDEF}, 8'hFF, 1'b1, 16'h000A);
		alu('{FM_CLR, FM_CLR, FM_CLR, FM_CLR, FM_CLR}, 8'h00, 1'b0, 16'h0008);
		repeat (16)
		begin
			{base_reg, wide_index_offset, operand_addr, next_insn_addr} = {$urandom, $urandom};
			{direct_addr, branch_disp, bit_index, alu_in_a, alu_in_m} = 35'({$urandom, $urandom});
			{pc, acc, idx_low} = $urandom;
			tick();
			chk(8, {8'h00, direct_addr});
			chk(9, base_reg + wide_index_offset);
			chk(10, next_insn_addr + {{8{branch_disp[7]}}, branch_disp});
			chk(11, operand_addr);
			chk(12, operand_addr + 16'h0001);
			chk(13, 16'(8'h01 << bit_index));
		end
		b = '{pc[7:0], pc[15:8], idx_low, acc, 8'h00};
		fire(1);
		chk(0, 16'h0000);
		chk(5, 16'h0000);
		tick(3);
		chk(5, 16'h0000);
		irq_req = 1'b1;
		await_out(15, 16'h0001);
		irq_req = 1'b0;
		chk(0, 16'h0001);
		foreach (b[i])
		begin
			tick();
			chk(14, 16'h0001);
			chk(6, 16'(b[i]));
		end
		tick(3);
		chk(5, 16'h0008);
		fire(0);
		chk(1, 16'h0000);
		chk(2, 16'h0000);
		host(3'h3);
		periodic_wake = 1'b1;
		tick(3);
		chk(3, 16'h0000);
		chk(0, 16'h0000);
		periodic_wake = 1'b0;
		ext_wake = 1'b1;
		await_out(0, 16'h0001);
		ext_wake = 1'b0;
		fire(0);
		irq_req = 1'b1;
		await_out(15, 16'h0001);
		irq_req = 1'b0;
		chk(0, 16'h0001);
		tick(8);
		keep = 1'b1;
		fire(0);
		chk(2, 16'h0001);
		chk(0, 16'h0000);
		periodic_wake = 1'b1;
		await_out(0, 16'h0001);
		{periodic_wake, keep} = '0;
		host(3'h4);
		await_out(4, 16'h0001);
		fire(0);
		chk(1, 16'h0001);
		host(3'h3);
		await_out(3, 16'h0001);
		chk(0, 16'h0001);
		for (int c = 0; c < 3; c++)
		begin
			host(3'(c));
			await_out(3, 16'h0000);
			fire(2);
			chk(3, 16'h0001);
			irq_req = 1'b1;
			tick(4);
			chk(3, 16'h0001);
			irq_req = 1'b0;
		end
		host(3'h0);
		await_out(3, 16'h0000);
		fire(1);
		host(3'h3);
		await_out(3, 16'h0001);
		chk(0, 16'h0001);
		host(3'h5);
		await_out(4, 16'h0000);
		rid = 1'b1;
		do_reset();
		chk(3, 16'h0001);
		chk(4, 16'h0001);
		tally_and_finish();
	end
endmodule // halt_ctrl_bench
`default_nettype wire
